// [core/lmx_pkg.sv]
// package: opcodes, field layouts, bus offsets and reset values of the literal/move executor
package lmx_pkg;
	// widths of the core state
	localparam int LMX_PC_W = 15;
	localparam int LMX_PTR_W = 16;
	localparam int LMX_IR_W = 14;
	// instruction encodings; those with a mask below are compared under it, the rest exactly
	localparam logic [13:0] LMX_OP_NOOP = 14'h0000;
	localparam logic [13:0] LMX_OP_RESET = 14'h0001;
	localparam logic [13:0] LMX_OP_RETFI = 14'h0009;
	localparam logic [13:0] LMX_OP_ISTORE = 14'h0018;
	localparam logic [13:0] LMX_MSK_ISTORE = 14'h3FF8;
	localparam logic [13:0] LMX_OP_LBANK = 14'h0020;
	localparam logic [13:0] LMX_MSK_LBANK = 14'h3FE0;
	localparam logic [13:0] LMX_OP_STWF = 14'h0080;
	localparam logic [13:0] LMX_MSK_STWF = 14'h3F80;
	localparam logic [13:0] LMX_OP_LWLIT = 14'h3000;
	localparam logic [13:0] LMX_MSK_LWLIT = 14'h3F00;
	localparam logic [13:0] LMX_OP_LPCL = 14'h3180;
	localparam logic [13:0] LMX_MSK_LPCL = 14'h3F80;
	localparam logic [13:0] LMX_OP_ISTREL = 14'h3F80;
	localparam logic [13:0] LMX_MSK_ISTREL = 14'h3F80;
	// operand field positions
	localparam int LMX_UPD_LSB = 0;
	localparam int LMX_N_BIT = 2;
	localparam int LMX_NK_BIT = 6;
	// pointer update modes
	localparam logic [1:0] LMX_UPD_PREINC = 2'h0;
	localparam logic [1:0] LMX_UPD_PREDEC = 2'h1;
	localparam logic [1:0] LMX_UPD_POSTINC = 2'h2;
	localparam logic [1:0] LMX_UPD_POSTDEC = 2'h3;
	// file addresses decoded by the core itself
	localparam logic [6:0] LMX_F_WIN0 = 7'h00;
	localparam logic [6:0] LMX_F_WIN1 = 7'h01;
	localparam logic [6:0] LMX_F_P0L = 7'h04;
	localparam logic [6:0] LMX_F_P0H = 7'h05;
	localparam logic [6:0] LMX_F_P1L = 7'h06;
	localparam logic [6:0] LMX_F_P1H = 7'h07;
	// wishbone byte offsets
	localparam logic [7:0] LMX_A_INSTR = 8'h00;
	localparam logic [7:0] LMX_A_STAT = 8'h04;
	localparam logic [7:0] LMX_A_WREG = 8'h08;
	localparam logic [7:0] LMX_A_BANK = 8'h0C;
	localparam logic [7:0] LMX_A_PCL = 8'h10;
	localparam logic [7:0] LMX_A_PC = 8'h14;
	localparam logic [7:0] LMX_A_PTR0 = 8'h18;
	localparam logic [7:0] LMX_A_PTR1 = 8'h1C;
	localparam logic [7:0] LMX_A_MADR = 8'h20;
	localparam logic [7:0] LMX_A_MDAT = 8'h24;
	// status register bits
	localparam int LMX_ST_BUSY = 0;
	localparam int LMX_ST_IRQEN = 1;
	localparam int LMX_ST_RSTINS = 2;
	// reset values
	localparam logic LMX_RSTINS_POR = 1'b1;
	localparam logic [7:0] LMX_W_RST = 8'h00;
	localparam logic [15:0] LMX_PTR_RST = 16'h0000;
	localparam logic [14:0] LMX_PC_RST = 15'h0000;
	// executor states
	typedef enum logic [1:0] {LMX_S_IDLE, LMX_S_EXEC, LMX_S_RET2, LMX_S_SRST} lmx_state_t;
endpackage

// [core/lmx_mem_if.sv]
// interface: data memory port between executor and memory
`timescale 1ns/1ps
interface lmx_mem_if #(parameter int AW = 8);
	logic we; // write strobe, one cycle
	logic [AW-1:0] waddr; // write address
	logic [7:0] wdata; // write data
	logic [AW-1:0] raddr; // read address
	logic [7:0] rdata; // registered read data
	modport master (output we, output waddr, output wdata, output raddr, input rdata);
	modport slave (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [core/lmx_dmem.sv]
// module: byte-wide data memory with registered read
`timescale 1ns/1ps
module lmx_dmem #(
	parameter int AW = 8
) (
	// clock
	input wire logic i_clk,
	// memory port
	lmx_mem_if.slave mem
);
	logic [7:0] ram [0:(1<<AW)-1]; // storage, no reset: contents are software's business
	logic [7:0] rdata_q; // read register
	// write port
	always_ff @(posedge i_clk) begin
		if (mem.we) begin
			ram[mem.waddr] <= mem.wdata;
		end
	end
	// read port, one cycle latency
	always_ff @(posedge i_clk) begin
		rdata_q <= ram[mem.raddr];
	end
	assign mem.rdata = rdata_q;
endmodule

// [core/lmx_ptr.sv]
// module: indirect pointer address and update arithmetic
`timescale 1ns/1ps
module lmx_ptr import lmx_pkg::*; (
	// pointer and operands
	input wire logic [15:0] i_ptr,
	input wire logic [1:0] i_mode,
	input wire logic i_rel,
	input wire logic [5:0] i_off,
	// results
	output logic [15:0] o_ea,
	output logic [15:0] o_next
);
	logic [15:0] inc; // sixteen-bit sums wrap by width
	logic [15:0] dec;
	logic [15:0] rel;
	assign inc = i_ptr + 16'h0001;
	assign dec = i_ptr - 16'h0001;
	assign rel = i_ptr + {{10{i_off[5]}}, i_off};
	// select address and pointer result
	always_comb begin
		o_ea = i_ptr;
		o_next = i_ptr;
		if (i_rel) begin
			o_ea = rel; // pointer stays put
		end else begin
			case (i_mode)
				LMX_UPD_PREINC: begin
					o_ea = inc;
					o_next = inc;
				end
				LMX_UPD_PREDEC: begin
					o_ea = dec;
					o_next = dec;
				end
				LMX_UPD_POSTINC: begin
					o_next = inc;
				end
				default: begin
					o_next = dec;
				end
			endcase
		end
	end
endmodule

// [core/lmx_top.sv]
// module: executor for literal loads, moves, indirect stores, reset and interrupt return
// Operation
// - bank literal loads the bank select register
// - pc latch literal loads high latch, flags kept
// - working literal loads accumulator, one cycle
// - store accumulator to addressed file register
// - indirect store writes accumulator through pointer
// - mode field picks pre/post increment/decrement
// - relative form adds signed offset, pointer kept
// - window registers redirect to pointer address
// - pointers are sixteen bits and wrap
// - pointer stepping never touches status flags
// - software reset resets device, clears reset flag
// - interrupt return pops stack, sets global enable
`timescale 1ns/1ps
module lmx_top import lmx_pkg::*; #(
	parameter int MEM_AW = 8
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// hardware stack
	input wire logic [14:0] i_stack_top,
	output logic o_stack_pop,
	// core state seen by neighbours
	output logic [14:0] o_pc,
	output logic [6:0] o_pc_latch,
	output logic o_global_irq_enable,
	output logic o_sw_reset
);
	logic rst_s1_q; // reset release synchroniser
	logic rst_s2_q;
	logic rstn; // synchronised reset
	logic ack_q; // bus answer
	logic [31:0] rdat_q; // bus read data
	logic req; // new bus access this cycle
	logic wr; // new write access
	lmx_state_t state_q; // executor state
	lmx_state_t state_d;
	logic [13:0] ir_q; // instruction being executed
	logic [7:0] w_q; // working accumulator
	logic [4:0] bank_q; // bank_select_reg
	logic [6:0] pcl_q; // pc_high_latch
	logic [14:0] pc_q; // program counter
	logic [15:0] ptr_q [0:1]; // indirect_pointer 0 and 1
	logic global_irq_enable_q; // global_irq_enable of irq_control_reg
	logic reset_instr_flag_q; // reset_instr_flag of power_control_reg
	logic [MEM_AW-1:0] madr_q; // bus view address into data memory
	logic exec; // executing a one-cycle step
	logic srst; // internal software reset pulse
	logic is_wi; // indirect_store_op, moded form
	logic is_wk; // indirect_store_op, relative form
	logic is_stwf; // store_working_to_file_op
	logic sel_n; // which pointer the store uses
	logic [15:0] ea; // effective address from pointer unit
	logic [15:0] ptr_nx; // updated pointer from pointer unit
	logic [6:0] fadr; // file address field
	logic [15:0] mem_tgt; // data memory target of the store
	logic mem_we; // store reaches data memory
	lmx_mem_if #(.AW(MEM_AW)) mem ();

	// bus-visible decode helper, used for read mux and writes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// opcode match under mask, used by every decoder term except the exact reset and interrupt return compares
	function automatic logic opm(input logic [13:0] ir, input logic [13:0] op,
		input logic [13:0] msk);
		return (ir & msk) == op;
	endfunction

	// reset: asynchronous assert, release through two flops
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rstn = rst_s2_q;

	// wishbone access detect; ack is one cycle, then dropped
	assign req = i_wb_cyc & i_wb_stb & ~ack_q;
	assign wr = req & i_wb_we & i_wb_sel[0];
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// read mux, registered; unmapped offsets read zero
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			rdat_q <= 32'h0000_0000;
		end else if (req && !i_wb_we) begin
			rdat_q <= 32'h0000_0000;
			if (hit(i_wb_adr, LMX_A_INSTR)) rdat_q[13:0] <= ir_q;
			if (hit(i_wb_adr, LMX_A_STAT)) begin
				rdat_q[LMX_ST_BUSY] <= state_q != LMX_S_IDLE;
				rdat_q[LMX_ST_IRQEN] <= global_irq_enable_q;
				rdat_q[LMX_ST_RSTINS] <= reset_instr_flag_q;
			end
			if (hit(i_wb_adr, LMX_A_WREG)) rdat_q[7:0] <= w_q;
			if (hit(i_wb_adr, LMX_A_BANK)) rdat_q[4:0] <= bank_q;
			if (hit(i_wb_adr, LMX_A_PCL)) rdat_q[6:0] <= pcl_q;
			if (hit(i_wb_adr, LMX_A_PC)) rdat_q[14:0] <= pc_q;
			if (hit(i_wb_adr, LMX_A_PTR0)) rdat_q[15:0] <= ptr_q[0];
			if (hit(i_wb_adr, LMX_A_PTR1)) rdat_q[15:0] <= ptr_q[1];
			if (hit(i_wb_adr, LMX_A_MADR)) rdat_q[MEM_AW-1:0] <= madr_q;
			if (hit(i_wb_adr, LMX_A_MDAT)) rdat_q[7:0] <= mem.rdata;
		end
	end
	assign o_wb_dat = rdat_q;
	assign o_wb_ack = ack_q;

	// instruction decode of the held word
	assign is_wi = opm(ir_q, LMX_OP_ISTORE, LMX_MSK_ISTORE);
	assign is_wk = opm(ir_q, LMX_OP_ISTREL, LMX_MSK_ISTREL);
	assign is_stwf = opm(ir_q, LMX_OP_STWF, LMX_MSK_STWF);
	assign fadr = ir_q[6:0];
	assign exec = state_q == LMX_S_EXEC;
	assign srst = state_q == LMX_S_SRST;
	// a store to a window register picks its pointer from the address
	assign sel_n = is_wk ? ir_q[LMX_NK_BIT] : is_wi ? ir_q[LMX_N_BIT] : fadr[0];

	// pointer arithmetic; a window store uses the relative form with zero offset
	lmx_ptr u_ptr (
		.i_ptr(ptr_q[sel_n]),
		.i_mode(ir_q[LMX_UPD_LSB +: 2]),
		.i_rel(~is_wi),
		.i_off(is_wk ? ir_q[5:0] : 6'h00),
		.o_ea(ea),
		.o_next(ptr_nx)
	);

	// executor sequencing: one step, or two for interrupt return and software reset
	always_comb begin
		state_d = state_q;
		case (state_q)
			LMX_S_IDLE: begin
				if (wr && hit(i_wb_adr, LMX_A_INSTR)) state_d = LMX_S_EXEC;
			end
			LMX_S_EXEC: begin
				if (ir_q == LMX_OP_RETFI) state_d = LMX_S_RET2;
				else if (ir_q == LMX_OP_RESET) state_d = LMX_S_SRST;
				else state_d = LMX_S_IDLE;
			end
			default: begin
				state_d = LMX_S_IDLE;
			end
		endcase
	end
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= LMX_S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// instruction register; a write while busy is dropped
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			ir_q <= LMX_OP_NOOP;
		end else if (state_q == LMX_S_IDLE && wr && hit(i_wb_adr, LMX_A_INSTR)) begin
			ir_q <= i_wb_dat[13:0];
		end
	end

	// working accumulator
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			w_q <= LMX_W_RST;
		end else if (srst) begin
			w_q <= LMX_W_RST;
		end else if (exec && opm(ir_q, LMX_OP_LWLIT, LMX_MSK_LWLIT)) begin
			w_q <= ir_q[7:0];
		end
	end

	// bank select and pc high latch
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			bank_q <= 5'h00;
			pcl_q <= 7'h00;
		end else if (srst) begin
			bank_q <= 5'h00;
			pcl_q <= 7'h00;
		end else if (exec) begin
			if (opm(ir_q, LMX_OP_LBANK, LMX_MSK_LBANK)) bank_q <= ir_q[4:0];
			if (opm(ir_q, LMX_OP_LPCL, LMX_MSK_LPCL)) pcl_q <= ir_q[6:0];
		end
	end

	// program counter: every step except interrupt return and software reset advances it, interrupt return reloads it
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			pc_q <= LMX_PC_RST;
		end else if (srst) begin
			pc_q <= LMX_PC_RST;
		end else if (state_q == LMX_S_RET2) begin
			pc_q <= i_stack_top;
		end else if (exec && ir_q != LMX_OP_RETFI && ir_q != LMX_OP_RESET) begin
			pc_q <= pc_q + 15'h0001;
		end
	end

	// indirect pointers: stepped by moded stores or written as bytes by file stores;
	// no status logic exists here, so stepping cannot touch a flag
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			ptr_q[0] <= LMX_PTR_RST;
			ptr_q[1] <= LMX_PTR_RST;
		end else if (srst) begin
			ptr_q[0] <= LMX_PTR_RST;
			ptr_q[1] <= LMX_PTR_RST;
		end else if (exec && is_wi) begin
			ptr_q[sel_n] <= ptr_nx;
		end else if (exec && is_stwf) begin
			if (fadr == LMX_F_P0L) ptr_q[0][7:0] <= w_q;
			if (fadr == LMX_F_P0H) ptr_q[0][15:8] <= w_q;
			if (fadr == LMX_F_P1L) ptr_q[1][7:0] <= w_q;
			if (fadr == LMX_F_P1H) ptr_q[1][15:8] <= w_q;
		end
	end

	// global interrupt enable; cleared by reset only in this block
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			global_irq_enable_q <= 1'b0;
		end else if (srst) begin
			global_irq_enable_q <= 1'b0;
		end else if (state_q == LMX_S_RET2) begin
			global_irq_enable_q <= 1'b1;
		end
	end

	// reset-source flag: power-on sets it, software reset clears it,
	// software may set it again through the status register
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			reset_instr_flag_q <= LMX_RSTINS_POR;
		end else if (srst) begin
			reset_instr_flag_q <= 1'b0;
		end else if (wr && hit(i_wb_adr, LMX_A_STAT) && i_wb_dat[LMX_ST_RSTINS]) begin
			reset_instr_flag_q <= 1'b1;
		end
	end

	// memory view address written by software
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			madr_q <= '0;
		end else if (srst) begin
			madr_q <= '0; // a software reset leaves the same view as power-up
		end else if (wr && hit(i_wb_adr, LMX_A_MADR)) begin
			madr_q <= i_wb_dat[MEM_AW-1:0];
		end
	end

	// store target: window addresses go through a pointer, others are banked direct;
	// pointer byte addresses are core registers and never reach memory
	always_comb begin
		mem_tgt = {4'h0, bank_q, fadr};
		mem_we = 1'b0;
		if (exec && (is_wi || is_wk)) begin
			mem_tgt = ea;
			mem_we = 1'b1;
		end else if (exec && is_stwf) begin
			if (fadr == LMX_F_WIN0 || fadr == LMX_F_WIN1) begin
				mem_tgt = ea;
				mem_we = 1'b1;
			end else if (fadr[6:2] != LMX_F_P0L[6:2]) begin
				mem_we = 1'b1;
			end
		end
	end
	assign mem.we = mem_we;
	assign mem.waddr = mem_tgt[MEM_AW-1:0];
	assign mem.wdata = w_q;
	assign mem.raddr = madr_q;

	// data memory; only the low address bits select a byte
	lmx_dmem #(.AW(MEM_AW)) u_dmem (
		.i_clk(i_mclk),
		.mem(mem)
	);

	// outputs to the core neighbours
	assign o_stack_pop = exec && ir_q == LMX_OP_RETFI;
	assign o_sw_reset = srst;
	assign o_pc = pc_q;
	assign o_pc_latch = pcl_q;
	assign o_global_irq_enable = global_irq_enable_q;
endmodule

// [tb/lmx_top_chk.sv]
// checker: bus, stack, latch and reset timing at the executor ports
`timescale 1ns/1ps
module lmx_top_chk (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// bus side
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	// stack and core state
	input wire logic [14:0] i_stack_top,
	input wire logic o_stack_pop,
	input wire logic [14:0] o_pc,
	input wire logic [6:0] o_pc_latch,
	input wire logic o_global_irq_enable,
	input wire logic o_sw_reset
);
	// one clock domain, so clocking and disable are given once
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	property p_ack_next; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause; o_wb_ack |-> $past(i_wb_cyc && i_wb_stb); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_pop_pc; o_stack_pop |=> ##[0:1] (o_pc == i_stack_top); endproperty
	a_pop_pc: assert property (p_pop_pc) else $error("pc not from stack");
	property p_pop_irq_en; o_stack_pop |=> ##[0:1] o_global_irq_enable; endproperty
	a_pop_irq_en: assert property (p_pop_irq_en) else $error("enable not set");
	property p_pop_once; o_stack_pop |=> !o_stack_pop; endproperty
	a_pop_once: assert property (p_pop_once) else $error("double pop");
	property p_irq_en_src;
		$rose(o_global_irq_enable) |-> $past(o_stack_pop) || $past(o_stack_pop, 2);
	endproperty
	a_irq_en_src: assert property (p_irq_en_src) else $error("enable rose alone");
	property p_srst;
		o_sw_reset |=> ##[0:1] (o_pc == 15'h0000 && !o_global_irq_enable
			&& o_pc_latch == 7'h00);
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset incomplete");
	// pc moves only by one step, a stack load or a reset
	property p_pc_step;
		$changed(o_pc) |-> (o_pc == $past(o_pc) + 15'h0001) || (o_pc == i_stack_top)
			|| (o_pc == 15'h0000);
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc jumped");
	// the latch only moves shortly after an issued bus cycle
	property p_latch_src;
		$changed(o_pc_latch) |-> $past(o_wb_ack) || $past(o_wb_ack, 2) || $past(o_wb_ack, 3);
	endproperty
	a_latch_src: assert property (p_latch_src) else $error("latch moved alone");
	c_pop: cover property (o_stack_pop);
	c_srst: cover property (o_sw_reset);
	c_wr: cover property (o_wb_ack && i_wb_we);
endmodule
bind lmx_top lmx_top_chk u_lmx_top_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop), .o_pc(o_pc),
	.o_pc_latch(o_pc_latch), .o_global_irq_enable(o_global_irq_enable),
	.o_sw_reset(o_sw_reset));

// [tb/lmx_top_bench.sv]
// testbench: drives the executor over wishbone and checks its results
`timescale 1ns/1ps
module lmx_top_bench import lmx_pkg::*; ;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [14:0] stk = 15'h1234; // return address, held steady
	logic [31:0] rdat, q;
	logic ack, pop, irq_en, srst;
	logic [14:0] pc;
	logic [6:0] latch;
	int err_count = 0;
	int n_checks = 0;
	int n_pop = 0; // stack pop pulses seen
	int n_srst = 0; // software reset pulses seen
	always #5 clk = ~clk;
	// count the one-cycle pulses so scenarios can judge how many came
	always @(posedge clk) begin
		if (pop === 1'b1) n_pop <= n_pop + 1;
		if (srst === 1'b1) n_srst <= n_srst + 1;
	end
	lmx_top u_lmx_top (.i_mclk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_stack_top(stk), .o_stack_pop(pop), .o_pc(pc),
		.o_pc_latch(latch), .o_global_irq_enable(irq_en), .o_sw_reset(srst));
	// prints the counts and the verdict, then stops
	task test_done();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; request held until ack is sampled high
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		if (n == 20) begin
			err_count++;
			test_done();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// issue an opcode and poll until the busy bit drops
	task ex(input logic [13:0] op);
		int n;
		wb(1'b1, LMX_A_INSTR, {18'h0, op});
		for (n = 0; n < 10; n++) begin
			wb(1'b0, LMX_A_STAT, 32'h0);
			if (q[LMX_ST_BUSY] === 1'b0) break;
		end
		if (n == 10) begin
			err_count++;
			test_done();
		end
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task mem_chk(input logic [7:0] a, input logic [7:0] e);
		wb(1'b1, LMX_A_MADR, {24'h0, a});
		rd_chk(LMX_A_MDAT, {24'h0, e});
	endtask
	task t_literals();
		ex(LMX_OP_LBANK | 14'h001F);
		rd_chk(LMX_A_BANK, 32'h0000_001F);
		ex(LMX_OP_LPCL | 14'h007F);
		chk({25'h0, latch}, 32'h0000_007F);
		rd_chk(LMX_A_PCL, 32'h0000_007F);
		ex(LMX_OP_LWLIT | 14'h00FF);
		rd_chk(LMX_A_WREG, 32'h0000_00FF);
		chk({17'h0, pc}, 32'h0000_0003);
		ex(LMX_OP_NOOP);
		chk({17'h0, pc}, 32'h0000_0004);
		rd_chk(LMX_A_PC, 32'h0000_0004);
		rd_chk(LMX_A_WREG, 32'h0000_00FF);
	endtask
	// w is 0xff: build pointer 0 = ffff, then a banked direct store
	task t_store_file();
		ex(LMX_OP_STWF | 14'h0004);
		ex(LMX_OP_STWF | 14'h0005);
		rd_chk(LMX_A_PTR0, 32'h0000_FFFF);
		ex(LMX_OP_LBANK | 14'h0001);
		ex(LMX_OP_LWLIT | 14'h004F);
		ex(LMX_OP_STWF | 14'h0010);
		mem_chk(8'h90, 8'h4F);
		ex(LMX_OP_STWF | {7'h0, LMX_F_WIN0});
		mem_chk(8'hFF, 8'h4F);
		rd_chk(LMX_A_PTR0, 32'h0000_FFFF);
	endtask
	// every update mode in turn, starting at ffff and each from the last result, crossing both ends of the range
	task t_modes();
		logic [7:0] ea [4] = '{8'h00, 8'hFF, 8'hFF, 8'h00};
		logic [15:0] np [4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
		for (int m = 0; m < 4; m++) begin
			ex(LMX_OP_LWLIT | (14'h0010 + 14'(m)));
			ex(LMX_OP_ISTORE | 14'(m));
			mem_chk(ea[m], 8'h10 + 8'(m));
			rd_chk(LMX_A_PTR0, {16'h0, np[m]});
		end
	endtask
	// pointer 1 = 0x0010, offsets at both limits
	task t_relative();
		ex(LMX_OP_LWLIT | 14'h0010);
		ex(LMX_OP_STWF | 14'h0006);
		ex(LMX_OP_LWLIT | 14'h0000);
		ex(LMX_OP_STWF | 14'h0007);
		ex(LMX_OP_LWLIT | 14'h00A5);
		ex(LMX_OP_ISTREL | 14'h0060);
		mem_chk(8'hF0, 8'hA5);
		ex(LMX_OP_ISTREL | 14'h005F);
		mem_chk(8'h2F, 8'hA5);
		rd_chk(LMX_A_PTR1, 32'h0000_0010);
	endtask
	task t_interrupt_return_op();
		ex(LMX_OP_RETFI);
		chk({17'h0, pc}, {17'h0, stk});
		rd_chk(LMX_A_PC, {17'h0, stk});
		chk({31'h0, irq_en}, 32'h0000_0001);
		chk(n_pop, 32'h0000_0001);
	endtask
	task t_swreset();
		ex(LMX_OP_RESET);
		chk(n_srst, 32'h0000_0001);
		chk({17'h0, pc}, 32'h0000_0000);
		chk({25'h0, latch}, 32'h0000_0000);
		wb(1'b0, LMX_A_STAT, 32'h0);
		chk({29'h0, q[2:0]}, 32'h0000_0000);
		rd_chk(LMX_A_WREG, 32'h0000_0000);
		rd_chk(LMX_A_PTR1, 32'h0000_0000);
		rd_chk(LMX_A_BANK, 32'h0000_0000);
		wb(1'b1, LMX_A_STAT, 32'h0000_0004);
		wb(1'b0, LMX_A_STAT, 32'h0);
		chk({31'h0, q[LMX_ST_RSTINS]}, 32'h0000_0001);
		rd_chk(8'h3C, 32'h0000_0000);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		wb(1'b0, LMX_A_STAT, 32'h0);
		chk({29'h0, q[2:0]}, 32'h0000_0004);
		t_literals();
		t_store_file();
		t_modes();
		t_relative();
		t_interrupt_return_op();
		t_swreset();
		test_done();
	end
endmodule
